// ==== inc/sepc_defines.svh ====
// constants of the serial eeprom command and protection block
//
// Behaviour
// R1: low opcode bits 001 write status, 011 read array, 010 write array; bit 3 ignored.
// R2: after reset the write-enable latch is clear; each program needs a latch set first.
// R3: latch clear blocks all programming, whatever the write-protect pin shows.
// R4: status read shifts out the status byte; protect bits change only by status write. The code also clears them at reset.
// R5: status bits: 7 pin protect, 6-4 unused, 3-2 block protect, 1 write enabled, 0 busy.
// R6: busy bit is 0 when ready and 1 during a self-timed write cycle.
// R7: bits 6-4 read 0 when idle; all eight bits read 1 during a write cycle.
// R8: small variant block codes protect none, 0300-03FF, 0200-03FF, 0000-03FF.
// R9: large variant block codes protect none, 0600-07FF, 0400-07FF, 0000-07FF.
// R10: protect bits are kept cells; changing them needs latch set and a full write cycle. The code loads them with 0 at reset, without the latch.
// R11: hardware protection is on only with pin low and pin-protect enable set.
// R12: hardware protection rejects status writes and protected writes, not unprotected ones.
// R13: pin-protect enable cannot be cleared while hardware protection holds.
// R14: read takes opcode and 16-bit address, then shifts data out msb first.
// R15: continuous read increments address and wraps from top to zero.
// R16: array write needs latch set and an address outside the protected range.
// R17: during a write cycle every instruction but status read is ignored.
// R18: write takes opcode, address and data; programming starts at chip select rise.
// R19: master raises chip select right after the last data bit, else no write starts.
// R20: page write of 32 bytes; only the five low address bits increment and wrap.
// R21: the write-enable latch clears when a write cycle completes.
// R22: write without latch set is dropped; standby until the next select falls.
// R23: low opcode bits 110 latch set, 100 latch clear, 101 status read; bit 3 ignored.
// R24: bad opcode: ignore input, output stays off until the next select falls.
// R25: all bytes msb first; each transaction begins with chip select falling.
// R26: with pin protection on, pin low during the frame aborts a status write.
// R27: only ten or eleven low address bits count; upper address bits are ignored.
`ifndef SEPC_DEFINES_SVH
`define SEPC_DEFINES_SVH
`define SEPC_OP_ST_WR 3'h1
`define SEPC_OP_WRITE 3'h2
`define SEPC_OP_READ 3'h3
`define SEPC_OP_LATCH_CLR 3'h4
`define SEPC_OP_ST_RD 3'h5
`define SEPC_OP_LATCH_SET 3'h6
`define SEPC_ST_PIN_EN 7
`define SEPC_ST_BPHI 3
`define SEPC_ST_BPLO 2
`define SEPC_ST_BUSY_ALL 8'hFF
`define SEPC_PIN_EN_RST 1'b0
`define SEPC_BP_RST 2'h0
`define SEPC_WEL_RST 1'b0
`define SEPC_TWC_MS 5
`define SEPC_CLK_KHZ 125000
`define SEPC_MASK_SMALL 11'h3FF
`define SEPC_MASK_LARGE 11'h7FF
`define SEPC_SIZE_SMALL 12'h400
`define SEPC_SIZE_LARGE 12'h800
`define SEPC_CELLS 2048
`define SEPC_PAGE 32
`endif

// ==== inc/sepc_pkg.sv ====
// types of the serial eeprom command and protection block
package sepc_pkg;
  typedef enum logic [2:0] {
    SEPC_CMD_NONE, SEPC_CMD_ST_WR, SEPC_CMD_WRITE, SEPC_CMD_READ,
    SEPC_CMD_LATCH_CLR, SEPC_CMD_ST_RD, SEPC_CMD_LATCH_SET, SEPC_CMD_BAD
  } sepc_cmd_e;
  // gray along opcode, address, data
  typedef enum logic [1:0] {
    SEPC_LK_OPC = 2'h0, SEPC_LK_ADDR = 2'h1, SEPC_LK_DATA = 2'h3, SEPC_LK_DEAD = 2'h2
  } sepc_link_e;
endpackage

// ==== src/sepc_link.sv ====
// serial clock side: shifter, opcode decode, address and page buffer
`timescale 1ns/1ns
`include "sepc_defines.svh"
module sepc_link import sepc_pkg::*; (
  // link pins
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  // core side, outputs stable while chip select is high
  input wire logic busy_in,
  input wire logic [7:0] status_in,
  input wire logic [7:0] rd_data_in,
  output sepc_cmd_e cmd_out,
  output logic [15:0] addr_out,
  output logic [255:0] page_out,
  output logic [31:0] mask_out,
  output logic [7:0] sr_out,
  output logic sr_got_out,
  output logic aligned_out
);
  sepc_link_e state;
  logic [2:0] bit_cnt;
  logic [6:0] rx;
  logic first, hi_done, busy_m, busy_s;
  wire [7:0] byte_w = {rx, si_in};
  wire byte_end = (bit_cnt == 3'h7);
  wire [2:0] op_lo = byte_w[2:0];
  // R1 R23 opcode decode, bit 3 ignored
  wire sepc_cmd_e dec = (byte_w[7:4] != 4'h0) ? SEPC_CMD_BAD :
    (op_lo == `SEPC_OP_ST_WR) ? SEPC_CMD_ST_WR :
    (op_lo == `SEPC_OP_WRITE) ? SEPC_CMD_WRITE :
    (op_lo == `SEPC_OP_READ) ? SEPC_CMD_READ :
    (op_lo == `SEPC_OP_LATCH_CLR) ? SEPC_CMD_LATCH_CLR :
    (op_lo == `SEPC_OP_ST_RD) ? SEPC_CMD_ST_RD :
    (op_lo == `SEPC_OP_LATCH_SET) ? SEPC_CMD_LATCH_SET :
    SEPC_CMD_BAD;
  // R24 R17 bad opcode or read while busy goes dead
  wire sepc_link_e st_opc = (dec == SEPC_CMD_READ) ? (busy_s ? SEPC_LK_DEAD : SEPC_LK_ADDR) :
    (dec == SEPC_CMD_WRITE) ? SEPC_LK_ADDR :
    (dec == SEPC_CMD_ST_RD || dec == SEPC_CMD_ST_WR) ? SEPC_LK_DATA : SEPC_LK_DEAD;
  wire in_data = (state == SEPC_LK_DATA);
  wire wr_byte = in_data && byte_end && (cmd_out == SEPC_CMD_WRITE);
  wire [31:0] mask_base = first ? 32'h0 : mask_out;
  wire [7:0] tx_byte = (cmd_out == SEPC_CMD_ST_RD) ?
    (busy_s ? `SEPC_ST_BUSY_ALL : status_in) : rd_data_in;
  //////////////////////////////////////////////////////////////////////////////
  // R25 frame state cleared while deselected
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      state <= SEPC_LK_OPC;
      bit_cnt <= 3'h0;
      first <= 1'b1;
      hi_done <= 1'b0;
    end else begin
      first <= 1'b0;
      bit_cnt <= bit_cnt + 3'h1;
      if (byte_end) begin
        case (state)
          SEPC_LK_OPC: state <= st_opc;
          SEPC_LK_ADDR: begin
            hi_done <= 1'b1;
            if (hi_done) state <= SEPC_LK_DATA;
          end
          SEPC_LK_DATA: if (cmd_out == SEPC_CMD_ST_WR) state <= SEPC_LK_DEAD;
          default: state <= SEPC_LK_DEAD;
        endcase
      end
    end
  end
  // busy level only reaches the shifter through two flops
  always_ff @(posedge sck_in) begin
    busy_m <= busy_in;
    busy_s <= busy_m;
  end
  // frame data held after select rises, read by the core then
  always_ff @(posedge sck_in) begin
    rx <= byte_w[6:0];
    aligned_out <= byte_end;
    if (first) sr_got_out <= 1'b0;
    mask_out <= mask_base;
    if (byte_end && state == SEPC_LK_OPC) cmd_out <= dec;
    if (byte_end && state == SEPC_LK_ADDR) addr_out <= {addr_out[7:0], byte_w};
    // R15 read address steps after each byte
    if (in_data && byte_end && cmd_out == SEPC_CMD_READ) addr_out <= addr_out + 16'h1;
    // R20 page write steps low five bits only
    if (wr_byte) begin
      addr_out[4:0] <= addr_out[4:0] + 5'h1;
      page_out[addr_out[4:0]*8 +: 8] <= byte_w;
      mask_out <= mask_base | (32'h1 << addr_out[4:0]);
    end
    if (in_data && byte_end && cmd_out == SEPC_CMD_ST_WR) begin
      sr_out <= byte_w;
      sr_got_out <= 1'b1;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // R14 output on falling edge, msb first
  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      so_out <= 1'b0;
      so_oe_out <= 1'b0;
    end else begin
      so_oe_out <= in_data && (cmd_out == SEPC_CMD_READ || cmd_out == SEPC_CMD_ST_RD);
      so_out <= tx_byte[~bit_cnt];
    end
  end
endmodule // sepc_link

// ==== src/sepc_top.sv ====
// serial eeprom core: write latch, protection, write cycle and cell array
`timescale 1ns/1ns
`include "sepc_defines.svh"
module sepc_top import sepc_pkg::*; #(
  parameter bit LARGE_VARIANT = 1'b0,
  parameter int unsigned WRITE_CYCLES = `SEPC_TWC_MS * `SEPC_CLK_KHZ
) (
  // core clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // serial link
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  // write protect pin
  input wire logic wp_n_in,
  // state
  output logic busy_out
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  sepc_cmd_e cmd;
  logic [15:0] addr;
  logic [255:0] page_buf;
  logic [31:0] mask;
  logic [7:0] sr_byte;
  logic sr_got, aligned;
  logic cs_m, cs_s, cs_d, wp_m, wp_s;
  logic wel, busy, pin_protect_enable, wp_abort;
  logic [1:0] bp;
  logic [19:0] busy_cnt;
  logic [7:0] mem [0:`SEPC_CELLS-1];
  logic [7:0] rd_data;
  logic [7:0] status;

  //////////////////////////////////////////////////////////////////////////////
  // serial clock side

  sepc_link u_link (
    .sck_in(sck_in),
    .cs_n_in(cs_n_in),
    .si_in(si_in),
    .so_out(so_out),
    .so_oe_out(so_oe_out),
    .busy_in(busy),
    .status_in(status),
    .rd_data_in(rd_data),
    .cmd_out(cmd),
    .addr_out(addr),
    .page_out(page_buf),
    .mask_out(mask),
    .sr_out(sr_byte),
    .sr_got_out(sr_got),
    .aligned_out(aligned)
  );

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // second stage only is read; cs_d is the edge reference
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      wp_m <= 1'b1;
      wp_s <= 1'b1;
    end else begin
      cs_m <= cs_n_in;
      cs_s <= cs_m;
      cs_d <= cs_s;
      wp_m <= wp_n_in;
      wp_s <= wp_m;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // decode of a finished frame

  // link data is frozen once select is high, so it is safe to take here
  wire cs_rise = cs_s && !cs_d;
  // R17 only a status read passes while busy, and it needs no core action
  wire idle_evt = cs_rise && !busy;
  wire do_set = idle_evt && (cmd == SEPC_CMD_LATCH_SET);
  wire do_clr = idle_evt && (cmd == SEPC_CMD_LATCH_CLR);
  wire done = busy && (busy_cnt == 20'(WRITE_CYCLES - 1));

  // R27 unused upper address bits dropped
  wire [10:0] amask = LARGE_VARIANT ? `SEPC_MASK_LARGE : `SEPC_MASK_SMALL;
  wire [10:0] idx = addr[10:0] & amask;
  wire [11:0] size = LARGE_VARIANT ? `SEPC_SIZE_LARGE : `SEPC_SIZE_SMALL;

  // R8 R9 lower bound of the protected top part
  wire [11:0] lim = (bp == 2'h1) ? (size - {2'h0, size[11:2]}) :
                    (bp == 2'h2) ? {1'b0, size[11:1]} : 12'h0;
  wire page_prot = (bp != 2'h0) && ({1'b0, idx} >= lim);

  // R11 hardware protection
  wire hw_prot = pin_protect_enable && !wp_s;

  // R12 R26 R10 status write guard
  wire start_sr = idle_evt && (cmd == SEPC_CMD_ST_WR) && wel && sr_got && aligned &&
                  !hw_prot && !wp_abort;

  // R16 R19 R22 array write guard
  wire start_mem = idle_evt && (cmd == SEPC_CMD_WRITE) && wel && aligned &&
                   (mask != 32'h0) && !page_prot;

  wire start = start_sr || start_mem;

  //////////////////////////////////////////////////////////////////////////////
  // write-enable latch

  always_ff @(posedge clock_in) begin
    // R2 cleared at power-up
    if (rst_in) begin
      wel <= `SEPC_WEL_RST;
    // R21 cleared at cycle end
    end else if (done) begin
      wel <= 1'b0;
    end else if (do_set) begin
      wel <= 1'b1;
    // R3 clear ignores the pin
    end else if (do_clr) begin
      wel <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // with pin protect on, pin low during the frame aborts a status write

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wp_abort <= 1'b0;
    end else if (cs_s) begin
      wp_abort <= 1'b0;
    end else begin
      // R26 seen while selected
      wp_abort <= wp_abort || hw_prot;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // self-timed write cycle

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      busy <= 1'b0;
      busy_cnt <= 20'h0;
    // R18 starts only after select rises
    end else if (start) begin
      busy <= 1'b1;
      busy_cnt <= 20'h0;
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy) begin
      busy_cnt <= busy_cnt + 20'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // kept protection cells

  // cells are taken at start; reads show all ones until the cycle ends
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pin_protect_enable <= `SEPC_PIN_EN_RST;
      bp <= `SEPC_BP_RST;
    // R4 R13 only reset or a guarded status write changes them
    end else if (start_sr) begin
      pin_protect_enable <= sr_byte[`SEPC_ST_PIN_EN];
      bp <= sr_byte[`SEPC_ST_BPHI:`SEPC_ST_BPLO];
    end
  end

  // R5 R6 R7 status layout, unused bits zero
  assign status = {pin_protect_enable, 3'h0, bp, wel, busy};
  assign busy_out = busy;

  //////////////////////////////////////////////////////////////////////////////
  // cell array

  // one driver per cell; the whole page lands in one clock
  for (genvar gi = 0; gi < `SEPC_CELLS; gi++) begin : g_cell
    // R20 page write within the addressed page
    wire hit = start_mem && mask[gi % `SEPC_PAGE] && (idx[10:5] == 6'(gi / `SEPC_PAGE));
    always_ff @(posedge clock_in) begin
      if (hit) mem[gi] <= page_buf[(gi % `SEPC_PAGE) * 8 +: 8];
    end
  end

  // R15 masked index wraps top to zero
  assign rd_data = mem[idx];

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  property p_powerup;
    @(posedge clock_in) disable iff (1'b0) rst_in |=> !wel && !busy;
  endproperty
  a_powerup: assert property (p_powerup) else $error("latch or busy set after reset"); // R2

  property p_latch_clr;
    do_clr |=> !wel;
  endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch clear did not clear"); // R3

  property p_bp_src;
    ($changed(bp) || $changed(pin_protect_enable)) && !$past(rst_in) |-> $past(start_sr);
  endproperty
  a_bp_src: assert property (p_bp_src) else $error("protect bits moved without write"); // R4

  property p_busy_len;
    $fell(busy) |-> $past(busy_cnt) == 20'(WRITE_CYCLES - 1);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong"); // R6

  property p_wel_done;
    $fell(busy) |-> !wel;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch kept after cycle"); // R21

  property p_mem_guard;
    start_mem |-> wel && !page_prot && !busy;
  endproperty
  a_mem_guard: assert property (p_mem_guard) else $error("array write not allowed"); // R16

  property p_pin_en_keep;
    (pin_protect_enable && !wp_s) |=> pin_protect_enable;
  endproperty
  a_pin_en_keep: assert property (p_pin_en_keep) else $error("pin protect bit cleared"); // R13

  property p_hw_block;
    $rose(busy) && $past(hw_prot) |-> $past(cmd) == SEPC_CMD_WRITE;
  endproperty
  a_hw_block: assert property (p_hw_block) else $error("status write under protection"); // R12

  property p_ignore;
    (busy && cs_rise && !done) |=> (wel == $past(wel)) && (bp == $past(bp)) && busy;
  endproperty
  a_ignore: assert property (p_ignore) else $error("command acted during cycle"); // R17

  property p_abort;
    wp_abort && cs_rise |=> !$rose(busy) || $past(cmd) == SEPC_CMD_WRITE;
  endproperty
  a_abort: assert property (p_abort) else $error("aborted status write started"); // R26

  property p_start_cs;
    $rose(busy) |-> $past(cs_rise) && $past(wel);
  endproperty
  a_start_cs: assert property (p_start_cs) else $error("cycle started off select rise"); // R18

  property p_status;
    status[6:4] == 3'h0 ##0 status[0] == busy;
  endproperty
  a_status: assert property (p_status) else $error("status layout wrong"); // R7

  property p_prot_quarter;
    start_mem && bp == 2'h1 |-> (LARGE_VARIANT ? idx[10:9] != 2'h3 : idx[9:8] != 2'h3);
  endproperty
  a_prot_quarter: assert property (p_prot_quarter) else $error("top quarter written"); // R9

  property p_prot_half;
    start_mem && bp == 2'h2 |-> (LARGE_VARIANT ? !idx[10] : !idx[9]);
  endproperty
  a_prot_half: assert property (p_prot_half) else $error("top half written"); // R9

  property p_prot_all;
    start_mem |-> bp != 2'h3;
  endproperty
  a_prot_all: assert property (p_prot_all) else $error("fully protected array written"); // R8

  property p_sr_latch;
    start_sr |-> wel && sr_got && !busy;
  endproperty
  a_sr_latch: assert property (p_sr_latch) else $error("status write without latch"); // R10

  property p_hw_pin;
    start_sr |-> !pin_protect_enable || wp_s;
  endproperty
  a_hw_pin: assert property (p_hw_pin) else $error("status write with pin protect on"); // R11

  property p_latch_set;
    do_set |=> wel;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set did not set"); // R23

  property p_bad_op;
    cs_rise && !busy && cmd == SEPC_CMD_BAD |=> (wel == $past(wel)) && !busy;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad opcode acted"); // R24

  property p_no_latch;
    cs_rise && !busy && !wel && cmd == SEPC_CMD_WRITE |=> !busy;
  endproperty
  a_no_latch: assert property (p_no_latch) else $error("write ran without latch"); // R22

  property p_cut_frame;
    cs_rise && !busy && !aligned |=> !busy;
  endproperty
  a_cut_frame: assert property (p_cut_frame) else $error("cut frame started a cycle"); // R19

  property p_busy_bit;
    busy |-> status[0];
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit low during cycle"); // R6

  property p_done_end;
    done |=> !busy && !wel;
  endproperty
  a_done_end: assert property (p_done_end) else $error("cycle end left latch or busy"); // R21

  property p_cnt_bound;
    busy |-> busy_cnt < 20'(WRITE_CYCLES);
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("cycle counter overran"); // R6

  property p_abort_flag;
    !cs_s && hw_prot |=> wp_abort;
  endproperty
  a_abort_flag: assert property (p_abort_flag) else $error("pin low not recorded"); // R26

  property p_slot;
    start_mem |-> aligned && (mask != 32'h0);
  endproperty
  a_slot: assert property (p_slot) else $error("array write with no byte"); // R20

  c_mem_cycle: cover property (start_mem);
  c_sr_cycle: cover property (start_sr);
  c_done: cover property ($fell(busy));
  c_poll: cover property (busy && cs_rise);
  c_prot_drop: cover property (idle_evt && cmd == SEPC_CMD_WRITE && page_prot);

endmodule // sepc_top

// ==== bench/sepc_spi_master.sv ====
// spi master model driving the eeprom link in mode 0
`timescale 1ns/1ns
module sepc_spi_master (
  // link pins
  output logic sck_out,
  output logic cs_n_out,
  output logic si_out,
  // answer from device
  input wire logic so_in,
  input wire logic so_oe_in
);
  logic oe_seen;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
    oe_seen = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // frame opens with select falling
  task automatic open_frame();
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    #10;
  endtask
  // msb first, sampled at rising edge
  task automatic xfer_byte(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      si_out = tx[i];
      #3 sck_out = 1'b1;
      rx[i] = so_in;
      oe_seen = oe_seen | so_oe_in;
      #3 sck_out = 1'b0;
    end
  endtask
  // select rises in the low time after the last bit
  task automatic close_frame();
    #2 cs_n_out = 1'b1;
    // released line must not keep its last level
    si_out = ~si_out;
    // gap covers the core picking up the frozen frame
    #60;
  endtask
endmodule // sepc_spi_master

// ==== bench/spi_eeprom_cmd_protect_tb.sv ====
// self-checking bench of the eeprom command and protection block
`timescale 1ns/1ns
module spi_eeprom_cmd_protect_tb;
  logic clock_in;
  logic rst_in;
  logic wp_n;
  wire sck;
  wire cs_n;
  wire si;
  wire so;
  wire so_oe;
  wire busy;
  logic [7:0] rd [0:3];
  int bad_count;
  int check_count;
  int cyc;
  initial begin
    clock_in = 1'b0;
    rst_in = 1'b1;
    wp_n = 1'b1;
    bad_count = 0;
    check_count = 0;
    cyc = 0;
    forever #4 clock_in = ~clock_in;
  end
  // short write cycle keeps the run brief
  sepc_top #(.LARGE_VARIANT(1'b0), .WRITE_CYCLES(50)) dut_u (
    .clock_in(clock_in), .rst_in(rst_in), .sck_in(sck), .cs_n_in(cs_n),
    .si_in(si), .so_out(so), .so_oe_out(so_oe), .wp_n_in(wp_n), .busy_out(busy));
  sepc_spi_master master_u (
    .sck_out(sck), .cs_n_out(cs_n), .si_out(si), .so_in(so), .so_oe_in(so_oe));
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_of_test();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // n bytes of tx high first, then nrd read bytes, then tail stray bits
  task automatic frame(input logic [47:0] tx, input int n, input int nrd, input int tail);
    logic [7:0] rx;
    master_u.open_frame();
    for (int i = n - 1; i >= 0; i--) master_u.xfer_byte(tx[8*i +: 8], 8, rx);
    for (int i = 0; i < nrd; i++) begin
      master_u.xfer_byte(8'hA5, 8, rx);
      rd[i] = rx;
    end
    if (tail > 0) master_u.xfer_byte(8'hC3, tail, rx);
    master_u.close_frame();
  endtask
  task automatic st();
    frame(48'h05, 1, 1, 0);
  endtask
  task automatic latch_set();
    frame(48'h06, 1, 0, 0);
  endtask
  // bounded poll of the busy bit
  task automatic wait_ready();
    for (int i = 0; i < 40; i++) begin
      st();
      if (rd[0][0] === 1'b0) break;
    end
    chk8({7'h00, busy}, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clock_in);
    #1 rst_in = 1'b0;
    repeat (3) @(posedge clock_in);
    st();
    chk8(rd[0], 8'h00);
    latch_set();
    st();
    chk8(rd[0], 8'h02);
    frame(48'h04, 1, 0, 0);
    st();
    chk8(rd[0], 8'h00);
    frame(48'h0E, 1, 0, 0);
    st();
    chk8(rd[0], 8'h02);
    // page write from one below top of page, upper address bits set
    frame(48'h02FFFE112233, 6, 0, 0);
    // status poll first: the whole byte lies well inside the cycle
    st();
    chk8(rd[0], 8'hFF);
    frame(48'h030000, 3, 1, 0);
    chk8({7'h00, master_u.oe_seen}, 8'h00);
    wait_ready();
    st();
    chk8(rd[0], 8'h00);
    latch_set();
    frame(48'h02000044, 4, 0, 0);
    wait_ready();
    frame(48'h0303FF, 3, 2, 0);
    chk8(rd[0], 8'h22);
    chk8(rd[1], 8'h44);
    frame(48'h0303E0, 3, 1, 0);
    chk8(rd[0], 8'h33);
    // write without latch is dropped
    frame(48'h02000055, 4, 0, 0);
    st();
    chk8(rd[0], 8'h00);
    frame(48'h030000, 3, 1, 0);
    chk8(rd[0], 8'h44);
    // select rise off the byte boundary
    latch_set();
    frame(48'h02000099, 4, 0, 3);
    st();
    chk8(rd[0] & 8'hFD, 8'h00);
    latch_set();
    frame(48'h018C, 2, 0, 0);
    wait_ready();
    st();
    chk8(rd[0], 8'h8C);
    @(posedge clock_in);
    #1 wp_n = 1'b0;
    latch_set();
    frame(48'h0100, 2, 0, 0);
    st();
    chk8(rd[0] & 8'hFD, 8'h8C);
    latch_set();
    frame(48'h02000066, 4, 0, 0);
    st();
    chk8(rd[0] & 8'hFD, 8'h8C);
    frame(48'h030000, 3, 1, 0);
    chk8(rd[0], 8'h44);
    @(posedge clock_in);
    #1 wp_n = 1'b1;
    latch_set();
    frame(48'h0104, 2, 0, 0);
    wait_ready();
    st();
    chk8(rd[0], 8'h04);
    latch_set();
    frame(48'h0202FF77, 4, 0, 0);
    wait_ready();
    latch_set();
    frame(48'h0203E088, 4, 0, 0);
    st();
    chk8(rd[0], 8'h06);
    frame(48'h0302FF, 3, 2, 0);
    chk8(rd[0], 8'h77);
    frame(48'h0303E0, 3, 1, 0);
    chk8(rd[0], 8'h33);
    frame(48'h20, 1, 1, 0);
    chk8({7'h00, master_u.oe_seen}, 8'h00);
    end_of_test();
  end
endmodule // spi_eeprom_cmd_protect_tb
